// ===== src/sfr_pkg.sv
// package for the supply fault response block: register map, fields, types
package sfr_pkg;

    // register byte addresses on the apb bus
    localparam logic [7:0] ADDR_STAT_A    = 8'h00; // supply_monitor_status_a
    localparam logic [7:0] ADDR_STAT_B    = 8'h04; // rail_monitor_status_b
    localparam logic [7:0] ADDR_SAFETY    = 8'h08; // safety_status_one
    localparam logic [7:0] ADDR_CFG       = 8'h0C; // mask and enable bits
    localparam logic [7:0] ADDR_STATE     = 8'h10; // response state and outputs

    // supply_monitor_status_a field positions
    localparam int A_MON_SUP   = 2;
    localparam int A_PUMP_L_UV = 3;
    localparam int A_PUMP_L_OV = 4;
    localparam int A_PUMP_H_OV = 5;
    localparam int A_BAT_UV    = 6;
    localparam int A_BAT_OV    = 7;

    // rail_monitor_status_b field positions
    localparam int B_CORE_UV   = 0;
    localparam int B_CORE_OV   = 1;
    localparam int B_IO_UV     = 2;
    localparam int B_IO_OV     = 3;
    localparam int B_CAN_UV    = 4;
    localparam int B_CAN_OV    = 5;
    localparam int B_PRE_UV    = 6;
    localparam int B_PRE_OV    = 7;

    // safety_status_one field positions
    localparam int S_SENS_OV   = 4;
    localparam int S_SENS_UV   = 5;

    // configuration field positions
    localparam int C_BAT_OV_MASK = 0;
    localparam int C_CORE_EN     = 1;
    localparam logic [1:0] CFG_RESET = 2'h2; // mask 0, core enable 1

    // deglitch: 15 us least filter time
    localparam int GLITCH_NS     = 15000;
    localparam int CLK_NS        = 4;
    localparam int GLITCH_CYC    = (GLITCH_NS + CLK_NS - 1) / CLK_NS;
    localparam int GLITCH_W      = $clog2(GLITCH_CYC + 1);
    localparam int NUM_CMP       = 20;

    // response state, one-hot
    typedef enum logic [3:0] {
        ST_RUN     = 4'h1,
        ST_DROP    = 4'h2,
        ST_RESET   = 4'h4,
        ST_STANDBY = 4'h8
    } sfr_state_t;

    // raw comparator results from the analog monitor
    typedef struct packed {
        logic bat_uv;
        logic bat_ov;
        logic pre_uv;
        logic pre_ov;
        logic can_uv;
        logic can_ov;
        logic io_uv;
        logic io_ov;
        logic core_uv;
        logic core_ov;
        logic sens_uv;
        logic sens_ov;
        logic pump_h_ov;
        logic pump_l_uv;
        logic pump_l_ov;
        logic mon_uv;
        logic mon_ov;
        logic ana_uv;
        logic ana_ov;
        logic dig_fault;
    } sfr_cmp_t;

    // apb request from the master
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } sfr_apb_req_t;

    // apb answer to the master
    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } sfr_apb_rsp_t;

endpackage

// ===== src/sfr_top.sv
// supply fault response: deglitch, status flags, severity-ordered response
//
// Summary of operation
// (RULE1) battery undervoltage: flag, standby, outputs low
// (RULE2) battery overvoltage: flag, reset unless masked
// (RULE3) prereg rail faults only flagged
// (RULE4) can rail undervoltage only flagged
// (RULE5) can rail overvoltage: flag, enable low
// (RULE6) io rail undervoltage: flag, reset, outputs low
// (RULE7) io rail overvoltage: flag, enable low
// (RULE8) core undervoltage: flag; reset if enabled
// (RULE9) core overvoltage: flag; enable low if enabled
// (RULE10) sensor rail faults flagged in safety status
// (RULE11) high pump overvoltage: flag, standby
// (RULE12) low pump undervoltage only flagged
// (RULE13) low pump overvoltage: flag, regulators off, standby
// (RULE14) monitor supply fault: flag, power-on reset, standby
// (RULE15) analog undervoltage or digital fault: standby
// (RULE16) flag reads one while supply out of band
// (RULE17) comparator results glitch-filtered before flags
// (RULE18) standby beats reset beats enable drop
// (RULE19) mcu reads status after fault response
//
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/100ps
module sfr_top
    import sfr_pkg::*;
(
    input  wire logic         mclk,         // 250 mhz clock
    input  wire logic         nrst,         // async reset, active low
    input  wire sfr_apb_req_t apb_req,      // apb request
    output sfr_apb_rsp_t      apb_rsp,      // apb answer
    input  wire sfr_cmp_t     cmp_raw,      // comparator results, async
    output logic              mcu_reset_output_n,     // mcu reset, low active
    output logic              power_stage_enable_out, // power stage enable
    output logic              internal_power_on_reset, // internal por pulse level
    output logic              regulators_off,         // downstream regs down
    output sfr_state_t        resp_state              // response state
);

    // ========================================================
    // input synchroniser
    // ========================================================
    logic [NUM_CMP-1:0] sync_a;
    logic [NUM_CMP-1:0] sync_b;

    // two flops before anything reads the analog results
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= cmp_raw;
            sync_b <= sync_a;
        end
    end

    // ========================================================
    // deglitch filters
    // ========================================================
    logic [NUM_CMP-1:0] filt;
    logic [NUM_CMP-1:0] next_filt;
    logic [GLITCH_W-1:0] cnt [NUM_CMP];
    logic [GLITCH_W-1:0] next_cnt [NUM_CMP];

    // (RULE17) filter each comparator
    // a level must hold a full filter time before it is taken
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CMP; gi++) begin : g_flt
            always_comb begin
                next_cnt[gi]  = cnt[gi];
                next_filt[gi] = filt[gi];
                if (sync_b[gi] == filt[gi]) begin
                    next_cnt[gi] = '0;
                end else if (cnt[gi] == GLITCH_W'(GLITCH_CYC - 1)) begin
                    next_cnt[gi]  = '0;
                    next_filt[gi] = sync_b[gi];
                end else begin
                    next_cnt[gi] = cnt[gi] + GLITCH_W'(1);
                end
            end
            always_ff @(posedge mclk or negedge nrst) begin
                if (!nrst) begin
                    cnt[gi]  <= '0;
                    filt[gi] <= 1'b0;
                end else begin
                    cnt[gi]  <= next_cnt[gi];
                    filt[gi] <= next_filt[gi];
                end
            end
        end
    endgenerate

    sfr_cmp_t f;
    assign f = sfr_cmp_t'(filt);

    // ========================================================
    // status flags, live view of filtered comparators
    // ========================================================
    logic [7:0] stat_a;
    logic [7:0] stat_b;
    logic [7:0] stat_s;
    logic [7:0] next_stat_a;
    logic [7:0] next_stat_b;
    logic [7:0] next_stat_s;

    // (RULE16) flag follows out-of-band condition
    // flags clear by themselves once the supply is back in band
    always_comb begin
        next_stat_a = 8'h00;
        next_stat_b = 8'h00;
        next_stat_s = 8'h00;
        // (RULE1) battery undervoltage flag
        next_stat_a[A_BAT_UV]    = f.bat_uv;
        // (RULE2) battery overvoltage flag
        next_stat_a[A_BAT_OV]    = f.bat_ov;
        // (RULE11) high pump flag
        next_stat_a[A_PUMP_H_OV] = f.pump_h_ov;
        // (RULE12) low pump undervoltage flag
        next_stat_a[A_PUMP_L_UV] = f.pump_l_uv;
        // (RULE13) low pump overvoltage flag
        next_stat_a[A_PUMP_L_OV] = f.pump_l_ov;
        // (RULE14) monitor supply flag
        next_stat_a[A_MON_SUP]   = f.mon_uv | f.mon_ov;
        // (RULE3) prereg flags
        next_stat_b[B_PRE_UV]    = f.pre_uv;
        next_stat_b[B_PRE_OV]    = f.pre_ov;
        // (RULE4) can undervoltage flag
        next_stat_b[B_CAN_UV]    = f.can_uv;
        // (RULE5) can overvoltage flag
        next_stat_b[B_CAN_OV]    = f.can_ov;
        // (RULE6) io undervoltage flag
        next_stat_b[B_IO_UV]     = f.io_uv;
        // (RULE7) io overvoltage flag
        next_stat_b[B_IO_OV]     = f.io_ov;
        // (RULE8) core undervoltage flag
        next_stat_b[B_CORE_UV]   = f.core_uv;
        // (RULE9) core overvoltage flag
        next_stat_b[B_CORE_OV]   = f.core_ov;
        // (RULE10) sensor rail flags
        next_stat_s[S_SENS_UV]   = f.sens_uv;
        next_stat_s[S_SENS_OV]   = f.sens_ov;
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            stat_a <= 8'h00;
            stat_b <= 8'h00;
            stat_s <= 8'h00;
        end else begin
            stat_a <= next_stat_a;
            stat_b <= next_stat_b;
            stat_s <= next_stat_s;
        end
    end

    // ========================================================
    // fault response
    // ========================================================
    logic [1:0] cfg;
    logic       want_stby;
    logic       want_rst;
    logic       want_drop;
    logic       want_por;
    sfr_state_t next_state;

    // classify the filtered faults by severity
    always_comb begin
        // (RULE15) analog undervoltage or digital fault, por
        // (RULE14) monitor supply fault raises por
        want_por  = f.ana_uv | f.dig_fault | f.mon_uv | f.mon_ov;
        // (RULE1) (RULE11) (RULE13) standby sources
        want_stby = want_por | f.bat_uv | f.pump_h_ov | f.pump_l_ov;
        // (RULE2) unmasked battery overvoltage reset
        // (RULE6) io undervoltage reset
        // (RULE8) core undervoltage reset when enabled
        want_rst  = (f.bat_ov & ~cfg[C_BAT_OV_MASK]) | f.io_uv | (f.core_uv & cfg[C_CORE_EN]);
        // (RULE5) (RULE7) (RULE9) enable drop sources
        want_drop = f.can_ov | f.io_ov | (f.core_ov & cfg[C_CORE_EN]);
        // (RULE18) most severe response wins
        if (want_stby) begin
            next_state = ST_STANDBY;
        end else if (want_rst) begin
            next_state = ST_RESET;
        end else if (want_drop) begin
            next_state = ST_DROP;
        end else begin
            next_state = ST_RUN;
        end
    end

    // outputs straight from flops; release follows fault removal,
    // reset extension belongs to the state controller outside
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            resp_state              <= ST_RUN;
            mcu_reset_output_n      <= 1'b0;
            power_stage_enable_out  <= 1'b0;
            internal_power_on_reset <= 1'b0;
            regulators_off          <= 1'b0;
        end else begin
            resp_state <= next_state;
            case (next_state)
                ST_STANDBY, ST_RESET: begin
                    mcu_reset_output_n     <= 1'b0;
                    power_stage_enable_out <= 1'b0;
                end
                ST_DROP: begin
                    mcu_reset_output_n     <= 1'b1;
                    power_stage_enable_out <= 1'b0;
                end
                default: begin
                    mcu_reset_output_n     <= 1'b1;
                    power_stage_enable_out <= 1'b1;
                end
            endcase
            internal_power_on_reset <= want_por;
            // (RULE13) low pump overvoltage stops regulators
            regulators_off <= f.pump_l_ov;
        end
    end

    // ========================================================
    // apb slave, zero wait states
    // ========================================================
    sfr_apb_rsp_t next_rsp;
    logic [1:0]   next_cfg;
    logic         acc;

    // (RULE19) status stays readable during any response
    always_comb begin
        acc      = apb_req.psel & apb_req.penable;
        next_cfg = cfg;
        next_rsp = '0;
        next_rsp.pready = apb_req.psel & ~apb_req.penable;
        if (apb_req.psel & ~apb_req.penable & ~apb_req.pwrite) begin
            case (apb_req.paddr)
                ADDR_STAT_A: next_rsp.prdata = {24'h000000, stat_a};
                ADDR_STAT_B: next_rsp.prdata = {24'h000000, stat_b};
                ADDR_SAFETY: next_rsp.prdata = {24'h000000, stat_s};
                ADDR_CFG:    next_rsp.prdata = {30'h00000000, cfg};
                ADDR_STATE:  next_rsp.prdata = {24'h000000, power_stage_enable_out,
                                                mcu_reset_output_n, regulators_off,
                                                internal_power_on_reset, resp_state};
                default:     next_rsp.pslverr = 1'b1;
            endcase
        end else if (apb_req.psel & ~apb_req.penable) begin
            next_rsp.pslverr = (apb_req.paddr != ADDR_CFG);
        end
        if (acc & apb_req.pwrite & (apb_req.paddr == ADDR_CFG)) begin
            next_cfg = apb_req.pwdata[1:0];
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cfg     <= CFG_RESET;
            apb_rsp <= '0;
        end else begin
            cfg     <= next_cfg;
            apb_rsp <= next_rsp;
        end
    end

    // ========================================================
    // checks
    // ========================================================
    AST_BAT_UV: assert property (@(posedge mclk) disable iff (!nrst) // (RULE1)
        f.bat_uv |=> (resp_state == ST_STANDBY) && !mcu_reset_output_n && !power_stage_enable_out)
        else $error("battery undervoltage did not force standby");

    AST_BAT_OV: assert property (@(posedge mclk) disable iff (!nrst) // (RULE2)
        (f.bat_ov && !cfg[C_BAT_OV_MASK] && !want_stby) |=> resp_state == ST_RESET)
        else $error("unmasked battery overvoltage did not force reset");

    AST_CAN_OV: assert property (@(posedge mclk) disable iff (!nrst) // (RULE5)
        f.can_ov |=> !power_stage_enable_out && stat_b[B_CAN_OV])
        else $error("can overvoltage did not drop enable");

    AST_IO_UV: assert property (@(posedge mclk) disable iff (!nrst) // (RULE6)
        (f.io_uv && !want_stby) |=> resp_state == ST_RESET && !mcu_reset_output_n)
        else $error("io undervoltage did not force reset");

    AST_CORE_MASK: assert property (@(posedge mclk) disable iff (!nrst) // (RULE8)
        (f.core_uv && !cfg[C_CORE_EN] && !want_stby && !want_rst && !want_drop) |=> mcu_reset_output_n)
        else $error("disabled core fault changed outputs");

    // sampled nrst keeps the release edge, where outputs still hold reset levels, out
    AST_QUIET: assert property (@(posedge mclk) disable iff (!nrst) // (RULE12)
        (nrst && !want_stby && !want_rst && !want_drop) |=> resp_state == ST_RUN && power_stage_enable_out)
        else $error("report-only fault changed outputs");

    AST_POR: assert property (@(posedge mclk) disable iff (!nrst) // (RULE14)
        (f.mon_ov || f.mon_uv) |=> internal_power_on_reset && stat_a[A_MON_SUP])
        else $error("monitor supply fault missed por");

    AST_GLITCH: assert property (@(posedge mclk) disable iff (!nrst) // (RULE17)
        $rose(filt[0]) |-> $past(sync_b[0], 2) && $past(sync_b[0], 1))
        else $error("flag set without stable input");

    AST_GLITCH_LEN: assert property (@(posedge mclk) disable iff (!nrst) // (RULE17)
        $rose(filt[0]) |-> $past(cnt[0]) == GLITCH_W'(GLITCH_CYC - 1))
        else $error("flag set before the full filter time");

    AST_CORE_OV: assert property (@(posedge mclk) disable iff (!nrst) // (RULE9)
        (f.core_ov && cfg[C_CORE_EN]) |=> !power_stage_enable_out && stat_b[B_CORE_OV])
        else $error("enabled core overvoltage did not drop enable");

    AST_SENS: assert property (@(posedge mclk) disable iff (!nrst) // (RULE10)
        (f.sens_uv || f.sens_ov) |=> stat_s[S_SENS_UV] == $past(f.sens_uv)
                                     && stat_s[S_SENS_OV] == $past(f.sens_ov))
        else $error("sensor rail flags wrong");

    AST_STBY: assert property (@(posedge mclk) disable iff (!nrst) // (RULE18)
        want_stby |=> resp_state == ST_STANDBY && !mcu_reset_output_n && !power_stage_enable_out)
        else $error("standby source lost to a milder response");

endmodule

// ===== dv/sfr_mcu_model.sv
// apb master standing in for the polling microcontroller
`timescale 1ns/100ps
module sfr_mcu_model
    import sfr_pkg::*;
(
    input  wire logic         mclk,    // bus clock
    input  wire sfr_apb_rsp_t apb_rsp, // answer from the block
    output sfr_apb_req_t      apb_req  // request to the block
);
    // ==========================================================
    // bus cycles
    initial apb_req = '0;

    // status polled by us
    // one transfer: setup, access held until pready, then release
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge mclk);
        apb_req.penable <= 1'b1;
        // no cycle limit here: only the bench watchdog ends a wait
        do begin
            @(posedge mclk);
        end while (apb_rsp.pready !== 1'b1);
        // released lines show the inverse, never a stale value
        apb_req <= '{psel: 1'b0, penable: 1'b0, pwrite: ~wr, paddr: ~a, pwdata: ~d};
    endtask
endmodule

// ===== dv/tb.sv
// self-checking testbench for the supply fault response block
`timescale 1ns/100ps
module tb
    import sfr_pkg::*;
;
    // ==========================================================
    // clock, signals, design
    logic         mclk = 1'b0;
    logic         nrst;
    sfr_apb_req_t apb_req;
    sfr_apb_rsp_t apb_rsp;
    sfr_cmp_t     cmp_raw;
    logic         rst_n_o;
    logic         en_o;
    logic         por_o;
    logic         regs_o;
    sfr_state_t   st_o;
    int           errors;
    int           checks;
    logic [31:0]  lfsr;
    logic [32:0]  exp_q[$];
    logic [32:0]  msk_q[$];

    always #2 mclk = ~mclk;

    sfr_top u_dut (
        .mclk                    (mclk),
        .nrst                    (nrst),
        .apb_req                 (apb_req),
        .apb_rsp                 (apb_rsp),
        .cmp_raw                 (cmp_raw),
        .mcu_reset_output_n      (rst_n_o),
        .power_stage_enable_out  (en_o),
        .internal_power_on_reset (por_o),
        .regulators_off          (regs_o),
        .resp_state              (st_o)
    );

    sfr_mcu_model u_mcu (
        .mclk    (mclk),
        .apb_rsp (apb_rsp),
        .apb_req (apb_req)
    );

    // ==========================================================
    // helpers
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], 1'b0} ^ (v[31] ? 32'h04C11DB7 : 32'h0);
    endfunction

    task automatic check(input string name, input logic [32:0] seen, input logic [32:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic summarize();
        // every noted answer must have been seen as well
        if (errors == 0 && checks > 0 && exp_q.size() == 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // note the expectation, then run the transfer
    task automatic bus(input logic wr, input logic [7:0] a, input logic [32:0] e, input logic [32:0] m);
        lfsr = lfsr_next(lfsr);
        exp_q.push_back(e);
        msk_q.push_back(m);
        u_mcu.xfer(wr, a, wr ? {30'h0, e[1:0]} : lfsr);
    endtask

    // answers are compared oldest note first, in the answer cycle
    always @(posedge mclk) begin
        logic [32:0] e;
        logic [32:0] m;
        if (apb_req.psel && apb_req.penable && apb_rsp.pready === 1'b1) begin
            e = exp_q.pop_front();
            m = msk_q.pop_front();
            check("apb answer", {apb_rsp.pslverr, apb_rsp.prdata} & m, e & m);
        end
    end

    // expected flags and response worked out from the fault vector
    task automatic check_all(input sfr_cmp_t c, input logic [1:0] cfg);
        logic        sb;
        logic        rkn;
        logic        rs;
        logic        dr;
        logic [3:0]  st;
        logic [7:0]  sr;
        logic [32:0] m;
        sb  = c.bat_uv | c.pump_h_ov | c.pump_l_ov | c.mon_uv | c.mon_ov | c.ana_uv | c.dig_fault;
        rkn = c.io_uv | (c.core_uv & cfg[C_CORE_EN]);
        rs  = rkn | (c.bat_ov & ~cfg[C_BAT_OV_MASK]);
        dr  = c.can_ov | c.io_ov | (c.core_ov & cfg[C_CORE_EN]);
        st  = sb ? ST_STANDBY : rs ? ST_RESET : dr ? ST_DROP : ST_RUN;
        sr  = {st == ST_RUN, ~(sb | rs), c.pump_l_ov, c.mon_uv | c.mon_ov | c.ana_uv | c.dig_fault, st};
        // output levels in a reset from unmasked battery overvoltage alone are left open
        m   = (st != ST_RESET || rkn) ? 33'h1FFFFFFFF : 33'h1FFFFFF3F;
        bus(0, ADDR_STAT_A, {25'h0, c.bat_ov, c.bat_uv, c.pump_h_ov, c.pump_l_ov, c.pump_l_uv,
            c.mon_uv | c.mon_ov, 2'h0}, '1);
        bus(0, ADDR_STAT_B, {25'h0, c.pre_ov, c.pre_uv, c.can_ov, c.can_uv, c.io_ov, c.io_uv,
            c.core_ov, c.core_uv}, '1);
        bus(0, ADDR_SAFETY, {27'h0, c.sens_uv, c.sens_ov, 4'h0}, '1);
        bus(0, ADDR_CFG, {31'h0, cfg}, '1);
        bus(0, ADDR_STATE, {25'h0, sr}, m);
        check("state", {29'h0, st_o}, {29'h0, st});
        check("por", {32'h0, por_o}, {32'h0, sr[4]});
        check("regs off", {32'h0, regs_o}, {32'h0, c.pump_l_ov});
        if (m[6]) begin
            check("reset out", {32'h0, rst_n_o}, {32'h0, sr[6]});
            check("enable out", {32'h0, en_o}, {32'h0, sr[7]});
        end
    endtask

    // one fault pattern under a random and then the inverted configuration
    task automatic step(input sfr_cmp_t c);
        logic [1:0] cfg;
        cfg = lfsr[1:0];
        @(posedge mclk);
        cmp_raw <= c;
        bus(1, ADDR_CFG, {31'h0, cfg}, 33'h100000000);
        repeat (3765) @(posedge mclk);
        check_all(c, cfg);
        bus(1, ADDR_CFG, {31'h0, ~cfg}, 33'h100000000);
        repeat (4) @(posedge mclk);
        check_all(c, ~cfg);
    endtask

    // ==========================================================
    // main sequence
    initial begin
        sfr_cmp_t c;
        nrst    = 1'b0;
        cmp_raw = '0;
        lfsr    = 32'hD968A2B8;
        errors  = 0;
        checks  = 0;
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        check_all('0, CFG_RESET);
        // refused accesses: unmapped read, read-only write
        bus(0, 8'h14, 33'h100000000, 33'h100000000);
        bus(1, ADDR_STAT_A, 33'h100000000, 33'h100000000);
        @(posedge mclk);
        cmp_raw <= '{bat_uv: 1'b1, default: 1'b0};
        repeat (1000) @(posedge mclk);
        cmp_raw <= '0;
        repeat (3765) @(posedge mclk);
        check_all('0, CFG_RESET);
        for (int i = 0; i < NUM_CMP; i++) begin
            step(sfr_cmp_t'(20'h1 << i));
        end
        c        = '0;
        c.io_uv  = 1'b1;
        c.can_ov = 1'b1;
        step(c);
        c.bat_uv = 1'b1;
        step(c);
        // let the monitor compare the last answer before closing
        repeat (2) @(posedge mclk);
        summarize();
    end

    // watchdog: the sequence needs about 89k cycles
    initial begin
        #390000;
        errors++;
        summarize();
    end
endmodule
